// ===== fciu_top.sv
`timescale 1ns/1ps
`include "fciu_cfg.svh"
module fciu_top #(
	parameter int unsigned XLEN         = 64,
	parameter logic [7:0]  OPC_LOADADDR = 8'h01,
	parameter logic [7:0]  OPC_LOOP     = 8'h02,
	parameter logic [7:0]  OPC_SYSCALL  = 8'h03,
	parameter logic [7:0]  OPC_HALT     = 8'h04,
	parameter logic [7:0]  OPC_RFE      = 8'h05,
	parameter logic [7:0]  OPC_CTX_SAVE = 8'h06,
	parameter logic [7:0]  OPC_CTX_REST = 8'h07,
	parameter logic [7:0]  OPC_SERIAL   = 8'h08,
	parameter bit          HAS_INC_UNIT = 1'b1
) (
	input  wire logic            CLK_I,
	input  wire logic            SYS_RST_I,
	input  wire logic            ID_VALID_I,
	input  wire logic [31:0]     ID_INSTR_I,
	input  wire logic [XLEN-1:0] ID_PC_I,
	input  wire logic [XLEN-1:0] ID_REG1_I,
	input  wire logic [XLEN-1:0] ID_REG2_I,
	input  wire logic            MEM_IDLE_I,
	input  wire logic            LOAD_STORE_FREE_I,
	input  wire logic            EXEC_IDLE_I,
	input  wire logic            SCB_CLEAR_I,
	input  wire logic            CTX_IDLE_I,
	input  wire logic            EXC_I,
	output logic                 ID_HOLD_O,
	output logic                 WB_EN_O,
	output logic [5:0]           WB_ADDR_O,
	output logic [XLEN-1:0]      WB_DATA_O,
	output logic                 BR_TAKEN_O,
	output logic [XLEN-1:0]      BR_TARGET_O,
	output logic                 SVC_TAKEN_O,
	output logic                 SVC_TRAP_O,
	output logic                 SUPERVISOR_O,
	output logic                 CTX_SWITCH_O,
	output logic                 CTX_RESTORE_PREV_O,
	output logic                 CTX_SAVE_O,
	output logic                 CTX_PREFETCH_O,
	output logic                 L0_FLUSH_O,
	output logic                 IDLE_O,
	output logic                 ILLEGAL_O,
	input  wire logic [7:0]      S_AXI_AWADDR,
	input  wire logic            S_AXI_AWVALID,
	output logic                 S_AXI_AWREADY,
	input  wire logic [31:0]     S_AXI_WDATA,
	input  wire logic [3:0]      S_AXI_WSTRB,
	input  wire logic            S_AXI_WVALID,
	output logic                 S_AXI_WREADY,
	output logic [1:0]           S_AXI_BRESP,
	output logic                 S_AXI_BVALID,
	input  wire logic            S_AXI_BREADY,
	input  wire logic [7:0]      S_AXI_ARADDR,
	input  wire logic            S_AXI_ARVALID,
	output logic                 S_AXI_ARREADY,
	output logic [31:0]          S_AXI_RDATA,
	output logic [1:0]           S_AXI_RRESP,
	output logic                 S_AXI_RVALID,
	input  wire logic            S_AXI_RREADY
);

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// one bit per condition group: mem, exec, ctx
	function automatic logic cond_met(input fciu_pkg::fciu_sermask_t m, input logic mem_ok,
			input logic exe_ok, input logic ctx_ok);
		return (!m[2] || mem_ok) && (!m[1] || exe_ok) && (!m[0] || ctx_ok);
	endfunction

	// old-value test and decrement run side by side in one cycle
	function automatic logic [XLEN-1:0] dec_count(input logic [XLEN-1:0] v);
		if (HAS_INC_UNIT) begin
			return v - {{(XLEN-1){1'b0}}, 1'b1};
		end
		return v + {XLEN{1'b1}};
	endfunction

	fciu_pkg::fciu_state_e state;
	fciu_pkg::fciu_state_e next_state;
	fciu_pkg::fciu_sermask_t ser_mask;
	logic                  user_mode;
	logic                  prev_user;
	logic                  trap_seen;
	logic [31:0]           svc_limit;
	logic [31:0]           base_lo;
	logic [31:0]           base_hi;

	// decode
	wire [7:0]  opc      = ID_INSTR_I[`FCIU_OPC_HI:`FCIU_OPC_LO];
	wire [5:0]  r1_num   = ID_INSTR_I[5:0];
	wire [15:0] svc_imm  = ID_INSTR_I[`FCIU_IMM_HI:`FCIU_IMM_LO];
	wire        exec_ok  = ID_VALID_I && !ID_HOLD_O;
	wire        ex_lent  = exec_ok && opc == OPC_LOADADDR && ID_INSTR_I[23:6] == 18'h0_0000;
	wire        ex_loop  = exec_ok && opc == OPC_LOOP && ID_INSTR_I[23:12] == 12'h000;
	wire        ex_svc   = exec_ok && opc == OPC_SYSCALL;
	wire        ex_halt  = exec_ok && opc == OPC_HALT;
	wire        ex_rfe   = exec_ok && opc == OPC_RFE;
	wire        ex_save  = exec_ok && opc == OPC_CTX_SAVE;
	wire        ex_rest  = exec_ok && opc == OPC_CTX_REST;
	wire        ex_ser   = exec_ok && opc == OPC_SERIAL;
	wire        ser_rsvd = ex_ser && ID_INSTR_I[19:0] != 20'h0_0000;
	wire        svc_trap = ex_svc && (ID_INSTR_I[`FCIU_TRAP_BIT] || ID_INSTR_I[22]);
	wire        mem_ok   = MEM_IDLE_I && LOAD_STORE_FREE_I;
	wire        exe_ok   = EXEC_IDLE_I && SCB_CLEAR_I;
	wire        ctx_ok   = CTX_IDLE_I;

	wire fciu_pkg::fciu_sermask_t new_mask = {ID_INSTR_I[`FCIU_SER_MEM],
		ID_INSTR_I[`FCIU_SER_EXEC], ID_INSTR_I[`FCIU_SER_CTX]};

	// full-length operands whatever the size bits say
	wire [XLEN-1:0] cnt_next   = dec_count(ID_REG1_I);
	wire            cnt_live   = ID_REG1_I != {XLEN{1'b0}};
	wire [XLEN-1:0] pc_next    = ID_PC_I + XLEN'(`FCIU_PC_STEP);
	wire [XLEN-1:0] svc_base   = XLEN'({base_hi, base_lo});
	wire [XLEN-1:0] svc_entry  = svc_base + (XLEN'(svc_imm) << `FCIU_ENTRY_SHIFT);
	wire            over_limit = {16'h0000, svc_imm} > svc_limit;

	wire        wb_req  = ex_lent || ex_loop || ex_svc;
	wire [XLEN-1:0] wb_val = ex_lent ? pc_next : (ex_loop ? cnt_next : {XLEN{1'b0}});

	// issue control
	always_comb begin
		next_state = state;
		unique case (state)
			fciu_pkg::ST_RUN, fciu_pkg::ST_SERIAL: begin
				if (ex_halt) begin
					next_state = fciu_pkg::ST_HALTED;
				end else if (ex_ser && !cond_met(new_mask, mem_ok, exe_ok, ctx_ok)) begin
					next_state = fciu_pkg::ST_SERIAL;
				end else if (!ID_HOLD_O) begin
					next_state = fciu_pkg::ST_RUN;
				end
			end
			fciu_pkg::ST_HALTED: begin
				if (EXC_I) begin
					next_state = fciu_pkg::ST_RUN;
				end
			end
		endcase
	end

	assign ID_HOLD_O = (state == fciu_pkg::ST_HALTED) ||
		(state == fciu_pkg::ST_SERIAL && !cond_met(ser_mask, mem_ok, exe_ok, ctx_ok));
	assign IDLE_O       = state == fciu_pkg::ST_HALTED;
	assign SUPERVISOR_O = !user_mode;

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			state    <= fciu_pkg::ST_RUN;
			ser_mask <= 3'b000;
		end else begin
			state <= next_state;
			if (ex_ser) begin
				ser_mask <= new_mask;
			end
		end
	end

	// execution results, one cycle after the instruction is taken
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			WB_EN_O            <= 1'b0;
			WB_ADDR_O          <= 6'h00;
			WB_DATA_O          <= {XLEN{1'b0}};
			BR_TAKEN_O         <= 1'b0;
			BR_TARGET_O        <= {XLEN{1'b0}};
			SVC_TAKEN_O        <= 1'b0;
			SVC_TRAP_O         <= 1'b0;
			CTX_SWITCH_O       <= 1'b0;
			CTX_RESTORE_PREV_O <= 1'b0;
			CTX_SAVE_O         <= 1'b0;
			CTX_PREFETCH_O     <= 1'b0;
			L0_FLUSH_O         <= 1'b0;
			ILLEGAL_O          <= 1'b0;
		end else begin
			WB_EN_O   <= wb_req && r1_num != 6'h00;
			WB_ADDR_O <= r1_num;
			WB_DATA_O <= wb_val;
			BR_TAKEN_O  <= (ex_loop && cnt_live) || ex_svc;
			BR_TARGET_O <= ex_svc ? svc_entry : ID_REG2_I;
			SVC_TAKEN_O <= ex_svc;
			SVC_TRAP_O  <= ex_svc && over_limit;
			CTX_SWITCH_O       <= svc_trap || (ex_halt && user_mode);
			CTX_RESTORE_PREV_O <= ex_rfe;
			CTX_SAVE_O         <= ex_save;
			CTX_PREFETCH_O     <= ex_rest;
			L0_FLUSH_O <= ex_ser && ID_INSTR_I[`FCIU_SER_FLUSH];
			ILLEGAL_O  <= ser_rsvd;
		end
	end

	// ---------------- register bus slave ----------------
	logic       aw_full;
	logic [7:0] aw_addr;
	logic       w_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       ar_take;

	assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_full && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;

	wire do_wr   = aw_full && w_full && !S_AXI_BVALID;
	wire wr_ctl  = do_wr && aw_addr == `FCIU_OFS_CTRL;
	wire wr_lim  = do_wr && aw_addr == `FCIU_OFS_LIMIT;
	wire wr_blo  = do_wr && aw_addr == `FCIU_OFS_BASE_LO;
	wire wr_bhi  = do_wr && aw_addr == `FCIU_OFS_BASE_HI;
	wire wr_st   = do_wr && aw_addr == `FCIU_OFS_STATUS;
	wire wr_hit  = wr_ctl || wr_lim || wr_blo || wr_bhi || wr_st;
	wire [31:0] ctl_new = apply_strb({31'h0, user_mode}, w_data, w_strb);
	wire [31:0] st_clr  = apply_strb(32'h0000_0000, w_data, w_strb);

	wire [31:0] st_word = {28'h000_0000, trap_seen, !user_mode,
		state == fciu_pkg::ST_SERIAL, state == fciu_pkg::ST_HALTED};
	wire rd_hit = S_AXI_ARADDR == `FCIU_OFS_CTRL || S_AXI_ARADDR == `FCIU_OFS_LIMIT ||
		S_AXI_ARADDR == `FCIU_OFS_BASE_LO || S_AXI_ARADDR == `FCIU_OFS_BASE_HI ||
		S_AXI_ARADDR == `FCIU_OFS_STATUS;
	wire [31:0] rd_mux =
		(S_AXI_ARADDR == `FCIU_OFS_CTRL)    ? {31'h0, user_mode} :
		(S_AXI_ARADDR == `FCIU_OFS_LIMIT)   ? svc_limit :
		(S_AXI_ARADDR == `FCIU_OFS_BASE_LO) ? base_lo :
		(S_AXI_ARADDR == `FCIU_OFS_BASE_HI) ? base_hi :
		(S_AXI_ARADDR == `FCIU_OFS_STATUS)  ? st_word : 32'h0000_0000;

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			aw_full      <= 1'b0;
			aw_addr      <= 8'h00;
			w_full       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `FCIU_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full <= 1'b1;
				aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_wr) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_hit ? `FCIU_RESP_OKAY : `FCIU_RESP_DECERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= `FCIU_RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_mux;
			S_AXI_RRESP  <= rd_hit ? `FCIU_RESP_OKAY : `FCIU_RESP_DECERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// software-visible state; instruction effects beat a same-cycle bus write
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			user_mode <= 1'(`FCIU_CTRL_RST);
			prev_user <= 1'b0;
			trap_seen <= 1'b0;
			svc_limit <= `FCIU_LIMIT_RST;
			base_lo   <= `FCIU_BASE_RST;
			base_hi   <= `FCIU_BASE_RST;
		end else begin
			if (ex_svc) begin
				prev_user <= user_mode;
				user_mode <= 1'b0;
			end else if (ex_rfe) begin
				user_mode <= prev_user;
			end else if (wr_ctl) begin
				user_mode <= ctl_new[`FCIU_CTRL_USER];
			end
			// a new trap outranks a clear in the same cycle
			if (ex_svc && over_limit) begin
				trap_seen <= 1'b1;
			end else if (wr_st && st_clr[`FCIU_ST_TRAP]) begin
				trap_seen <= 1'b0;
			end
			if (wr_lim) begin
				svc_limit <= apply_strb(svc_limit, w_data, w_strb);
			end
			if (wr_blo) begin
				base_lo <= apply_strb(base_lo, w_data, w_strb);
			end
			if (wr_bhi) begin
				base_hi <= apply_strb(base_hi, w_data, w_strb);
			end
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_lent_addr;
		ex_lent && r1_num != 6'h00 |=> WB_EN_O && WB_DATA_O == $past(ID_PC_I) + XLEN'(4);
	endproperty
	a_lent_addr: assert property (p_lent_addr) else $error("loopentry address wrong");

	property p_loop_br;
		ex_loop |=> BR_TAKEN_O == ($past(ID_REG1_I) != '0) && BR_TARGET_O == $past(ID_REG2_I);
	endproperty
	a_loop_br: assert property (p_loop_br) else $error("loop branch wrong");

	property p_loop_dec;
		ex_loop && r1_num != 6'h00 |=> WB_DATA_O == $past(ID_REG1_I) - XLEN'(1);
	endproperty
	a_loop_dec: assert property (p_loop_dec) else $error("loop count wrong");

	property p_r0;
		WB_EN_O |-> WB_ADDR_O != 6'h00;
	endproperty
	a_r0: assert property (p_r0) else $error("write to register zero");

	property p_svc;
		ex_svc |=> SUPERVISOR_O && SVC_TAKEN_O && WB_DATA_O == '0 &&
			BR_TARGET_O == $past(svc_base) + (XLEN'($past(svc_imm)) << 6);
	endproperty
	a_svc: assert property (p_svc) else $error("syscall entry wrong");

	property p_svc_trap;
		ex_svc |=> SVC_TRAP_O == ({16'h0000, $past(svc_imm)} > $past(svc_limit));
	endproperty
	a_svc_trap: assert property (p_svc_trap) else $error("service limit trap wrong");

	property p_halt;
		ex_halt ##1 !EXC_I |-> IDLE_O && ID_HOLD_O;
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not idle");

	property p_ser_hold;
		state == fciu_pkg::ST_SERIAL && ser_mask[2] && !MEM_IDLE_I |-> ID_HOLD_O;
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("issue not held");

	property p_flush;
		ex_ser && ID_INSTR_I[20] |=> L0_FLUSH_O;
	endproperty
	a_flush: assert property (p_flush) else $error("flush missing");

	property p_rfe;
		ex_rfe |=> CTX_RESTORE_PREV_O ##1 !CTX_RESTORE_PREV_O || $past(ex_rfe);
	endproperty
	a_rfe: assert property (p_rfe) else $error("restore pulse wrong");

endmodule // fciu_top

// ===== fciu_cfg.svh
`ifndef FCIU_CFG_SVH
`define FCIU_CFG_SVH

// register byte offsets on the bus
`define FCIU_OFS_CTRL      8'h00
`define FCIU_OFS_LIMIT     8'h04
`define FCIU_OFS_BASE_LO   8'h08
`define FCIU_OFS_BASE_HI   8'h0C
`define FCIU_OFS_STATUS    8'h10

// reset values
`define FCIU_CTRL_RST      32'h0000_0000
`define FCIU_LIMIT_RST     32'h0000_0000
`define FCIU_BASE_RST      32'h0000_0000

// control and status bit positions
`define FCIU_CTRL_USER     0
`define FCIU_ST_IDLE       0
`define FCIU_ST_SERWAIT    1
`define FCIU_ST_SUPER      2
`define FCIU_ST_TRAP       3

// instruction field positions
`define FCIU_OPC_HI        31
`define FCIU_OPC_LO        24
`define FCIU_TRAP_BIT      23
`define FCIU_SER_MEM       23
`define FCIU_SER_EXEC      22
`define FCIU_SER_CTX       21
`define FCIU_SER_FLUSH     20
`define FCIU_IMM_HI        21
`define FCIU_IMM_LO        6

// arithmetic constants
`define FCIU_PC_STEP       4
`define FCIU_ENTRY_SHIFT   6

// bus answers
`define FCIU_RESP_OKAY     2'b00
`define FCIU_RESP_DECERR   2'b11

`endif

// ===== fciu_pkg.sv
package fciu_pkg;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b001,
		ST_SERIAL = 3'b010,
		ST_HALTED = 3'b100
	} fciu_state_e;

	typedef logic [2:0] fciu_sermask_t;

endpackage

// ===== fciu_core_model.sv
`timescale 1ns/1ps
module fciu_core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       kick_i,
	input  wire logic [4:0] low_i,
	input  wire logic [7:0] len_i,
	output logic      [4:0] cond_o
);
	logic [7:0] cnt;
	logic [4:0] low;
	wire        busy = (cnt != 8'h00);
	// pipeline idle by default; a kick holds the chosen conditions false for len cycles
	assign cond_o = busy ? ~low : 5'h1f;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 8'h00;
			low <= 5'h00;
		end else if (kick_i) begin
			cnt <= len_i;
			low <= low_i;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule // fciu_core_model

// ===== fciu_tb_top.sv
`timescale 1ns/1ps
`include "fciu_cfg.svh"
module fciu_tb_top;
	localparam logic [7:0] OP_LA = 8'h41, OP_LP = 8'h52, OP_SC = 8'h63, OP_HT = 8'h74;
	localparam logic [7:0] OP_RF = 8'h85, OP_SV = 8'h96, OP_RS = 8'ha7, OP_SR = 8'hb8;
	logic        CLK_I, SYS_RST_I, ID_VALID_I, EXC_I, kick;
	logic [31:0] ID_INSTR_I, S_AXI_WDATA, rd;
	logic [63:0] ID_PC_I, ID_REG1_I, ID_REG2_I, pc, base, cnt;
	logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, len;
	logic        S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
	logic [3:0]  S_AXI_WSTRB;
	logic [4:0]  low;
	wire  [4:0]  cond;
	logic [1:0]  rsp;
	logic [15:0] imm, lim;
	int          fails, checks, seed, i, n, grp;
	wire         ID_HOLD_O, WB_EN_O, BR_TAKEN_O, SVC_TAKEN_O, SVC_TRAP_O, SUPERVISOR_O;
	wire         CTX_SWITCH_O, CTX_RESTORE_PREV_O, CTX_SAVE_O, CTX_PREFETCH_O, L0_FLUSH_O;
	wire         IDLE_O, ILLEGAL_O, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	wire         S_AXI_ARREADY, S_AXI_RVALID;
	wire  [5:0]  WB_ADDR_O;
	wire  [63:0] WB_DATA_O, BR_TARGET_O;
	wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	wire  [31:0] S_AXI_RDATA;

	fciu_top #(.OPC_LOADADDR(OP_LA), .OPC_LOOP(OP_LP), .OPC_SYSCALL(OP_SC), .OPC_HALT(OP_HT),
		.OPC_RFE(OP_RF), .OPC_CTX_SAVE(OP_SV), .OPC_CTX_REST(OP_RS), .OPC_SERIAL(OP_SR)) dut_u (
		.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ID_VALID_I(ID_VALID_I), .ID_INSTR_I(ID_INSTR_I),
		.ID_PC_I(ID_PC_I), .ID_REG1_I(ID_REG1_I), .ID_REG2_I(ID_REG2_I),
		.MEM_IDLE_I(cond[4]), .LOAD_STORE_FREE_I(cond[3]), .EXEC_IDLE_I(cond[2]),
		.SCB_CLEAR_I(cond[1]), .CTX_IDLE_I(cond[0]), .EXC_I(EXC_I), .ID_HOLD_O(ID_HOLD_O),
		.WB_EN_O(WB_EN_O), .WB_ADDR_O(WB_ADDR_O), .WB_DATA_O(WB_DATA_O),
		.BR_TAKEN_O(BR_TAKEN_O), .BR_TARGET_O(BR_TARGET_O), .SVC_TAKEN_O(SVC_TAKEN_O),
		.SVC_TRAP_O(SVC_TRAP_O), .SUPERVISOR_O(SUPERVISOR_O), .CTX_SWITCH_O(CTX_SWITCH_O),
		.CTX_RESTORE_PREV_O(CTX_RESTORE_PREV_O), .CTX_SAVE_O(CTX_SAVE_O),
		.CTX_PREFETCH_O(CTX_PREFETCH_O), .L0_FLUSH_O(L0_FLUSH_O), .IDLE_O(IDLE_O),
		.ILLEGAL_O(ILLEGAL_O), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY));

	fciu_core_model model_u (.clk_i(CLK_I), .rst_i(SYS_RST_I), .kick_i(kick), .low_i(low),
		.len_i(len), .cond_o(cond));

	initial begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end

	task automatic end_sim;
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [95:0] s, input logic [95:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// bus tasks end one step past the edge so a following call never reassigns in that step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		r = 2'bxx;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		forever begin
			@(posedge CLK_I);
			if (S_AXI_AWVALID && S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
			if (S_AXI_BVALID === 1'b1) begin
				r = S_AXI_BRESP;
				S_AXI_BREADY <= 1'b0;
				break;
			end
		end
		#1;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'bxx;
		d = 32'hxxxx_xxxx;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		forever begin
			@(posedge CLK_I);
			if (S_AXI_ARVALID && S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_RVALID === 1'b1) begin
				r = S_AXI_RRESP;
				d = S_AXI_RDATA;
				S_AXI_RREADY <= 1'b0;
				break;
			end
		end
		#1;
	endtask

	// offers one instruction, waits while held, checks land one step after the taking edge
	task automatic exec(input logic [31:0] ins, input logic [63:0] r1, input logic [63:0] r2);
		ID_INSTR_I <= ins;
		ID_REG1_I <= r1;
		ID_REG2_I <= r2;
		ID_PC_I <= pc;
		ID_VALID_I <= 1'b1;
		// only the watchdog ends a long hold
		do
			@(negedge CLK_I);
		while (ID_HOLD_O === 1'b1);
		@(posedge CLK_I);
		ID_VALID_I <= 1'b0;
		#1;
	endtask

	task automatic wake;
		@(posedge CLK_I);
		EXC_I <= 1'b1;
		@(posedge CLK_I);
		EXC_I <= 1'b0;
		for (n = 0; n < 5 && IDLE_O !== 1'b0; n++) @(posedge CLK_I);
		#1;
		chk("idle_end", {IDLE_O, ID_HOLD_O}, 2'b00);
	endtask

	initial begin
		repeat (20000) @(posedge CLK_I);
		fails++;
		end_sim();
	end

	initial begin
		seed = 42;
		{SYS_RST_I, ID_VALID_I, EXC_I, kick, low, len} = {1'b1, 3'b000, 5'h00, 8'h00};
		{ID_INSTR_I, ID_PC_I, ID_REG1_I, ID_REG2_I, pc} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		S_AXI_WSTRB = 4'hf;
		repeat (12) @(posedge CLK_I);
		SYS_RST_I <= 1'b0;
		#1;
		chk("rst_out", {SUPERVISOR_O, IDLE_O, ID_HOLD_O}, 3'b100);
		axi_rd(`FCIU_OFS_STATUS, rd, rsp);
		chk("status_rst", {rsp, rd}, {`FCIU_RESP_OKAY, 32'h0000_0004});
		axi_rd(8'h40, rd, rsp);
		chk("unmapped_rd", {rsp, rd}, {`FCIU_RESP_DECERR, 32'h0000_0000});
		axi_wr(8'h44, 32'h1234_5678, rsp);
		chk("unmapped_wr", rsp, `FCIU_RESP_DECERR);
		lim = 16'h0010 + ($random(seed) & 16'h00ff);
		base = {$random(seed), $random(seed)} & ~64'h3f;
		axi_wr(`FCIU_OFS_LIMIT, {16'h0000, lim}, rsp);
		axi_wr(`FCIU_OFS_BASE_LO, base[31:0], rsp);
		axi_wr(`FCIU_OFS_BASE_HI, base[63:32], rsp);
		axi_rd(`FCIU_OFS_BASE_HI, rd, rsp);
		chk("base_hi", {rsp, rd}, {`FCIU_RESP_OKAY, base[63:32]});
		for (i = 0; i < 10; i++) begin
			pc = {$random(seed), $random(seed)} & ~64'h3;
			n = (i == 0) ? 0 : 1 + ($random(seed) & 62);
			exec({OP_LA, 18'h0_0000, n[5:0]}, 64'h0, 64'h0);
			chk("le_en", WB_EN_O, n != 0);
			if (n != 0) chk("le_wb", {WB_ADDR_O, WB_DATA_O}, {n[5:0], pc + 64'h4});
		end
		// nonzero filler bits leave it undecoded as any instruction, so nothing is written
		exec({OP_LA, 18'h0_0001, 6'h05}, 64'h0, 64'h0);
		chk("le_rsvd", WB_EN_O, 1'b0);
		// counted loop issued back to back; count mirrors the decrement
		cnt = 64'h3;
		for (i = 0; i < 4; i++) begin
			exec({OP_LP, 12'h000, 6'h2, 6'h1}, cnt, base);
			chk("lp_br", {BR_TAKEN_O, WB_DATA_O}, {cnt != 0, cnt - 64'h1});
			if (cnt != 0) chk("lp_tgt", BR_TARGET_O, base);
			cnt = cnt - 64'h1;
		end
		chk("lp_final", WB_DATA_O, {64{1'b1}});
		for (i = 0; i < 12; i++) begin
			cnt = (i < 2) ? i : {$random(seed), $random(seed)};
			exec({OP_LP, 12'h000, 6'h2, 6'h1}, cnt, ~cnt);
			chk("lp_rnd", {BR_TAKEN_O, WB_DATA_O}, {cnt != 0, cnt - 64'h1});
		end
		for (i = 0; i < 4; i++) begin
			axi_wr(`FCIU_OFS_CTRL, 32'h0000_0001, rsp);
			imm = (i == 0) ? lim : (i == 1) ? lim + 16'h1 : $random(seed);
			exec({OP_SC, i[0], 1'b0, imm, i[1], 5'h03}, 64'h55, 64'h0);
			chk("sc_go", {SVC_TAKEN_O, BR_TAKEN_O, SUPERVISOR_O}, 3'b111);
			chk("sc_tgt", BR_TARGET_O, base + ({48'h0, imm} << 6));
			chk("sc_trap", SVC_TRAP_O, imm > lim);
			chk("sc_ctx", CTX_SWITCH_O, i[0]);
			chk("sc_clr", {WB_EN_O, WB_DATA_O}, {1'b1, 64'h0});
			exec({OP_RF, 24'h00_0000}, 64'h0, 64'h0);
			chk("rfe", {CTX_RESTORE_PREV_O, SUPERVISOR_O}, 2'b10);
		end
		// lim plus one trapped above, so the sticky bit must be up until cleared
		axi_rd(`FCIU_OFS_STATUS, rd, rsp);
		chk("trap_st", {rsp, rd}, {`FCIU_RESP_OKAY, 32'h0000_0008});
		axi_wr(`FCIU_OFS_STATUS, 32'h0000_0008, rsp);
		axi_rd(`FCIU_OFS_STATUS, rd, rsp);
		chk("trap_clr", {rsp, rd}, {`FCIU_RESP_OKAY, 32'h0000_0000});
		exec({OP_HT, 24'h00_0000}, 64'h0, 64'h0);
		chk("halt_user", {CTX_SWITCH_O, IDLE_O}, 2'b11);
		repeat (3) @(posedge CLK_I);
		#1;
		chk("halt_hold", ID_HOLD_O, 1'b1);
		wake();
		axi_wr(`FCIU_OFS_CTRL, 32'h0000_0000, rsp);
		exec({OP_HT, 24'h00_0000}, 64'h0, 64'h0);
		chk("halt_sup", {CTX_SWITCH_O, IDLE_O}, 2'b01);
		wake();
		exec({OP_SV, 24'h00_0000}, 64'h0, 64'h0);
		chk("save", {CTX_SAVE_O, CTX_PREFETCH_O}, 2'b10);
		exec({OP_RS, 24'h00_0000}, 64'h0, 64'h0);
		chk("restore", {CTX_SAVE_O, CTX_PREFETCH_O}, 2'b01);
		for (i = 0; i < 10; i++) begin
			grp = (i % 5 >= 3) ? 23 : (i % 5 >= 1) ? 22 : 21;
			if (i >= 5) grp = (grp == 23) ? 21 : 23;
			kick <= 1'b1;
			low <= 5'h01 << (i % 5);
			len <= 8'h06;
			@(posedge CLK_I);
			kick <= 1'b0;
			exec({OP_SR, 24'h00_0000} | (32'h1 << grp) | (i >= 5 ? 32'h10_0000 : 32'h0), 0, 0);
			chk("ser_flush", L0_FLUSH_O, i >= 5);
			for (n = 0; n < 20 && ID_HOLD_O === 1'b1; n++) @(posedge CLK_I) #1;
			chk("ser_wait", n, (i < 5) ? 5 : 0);
			repeat (8) @(posedge CLK_I);
		end
		exec({OP_SR, 24'h00_0010}, 64'h0, 64'h0);
		chk("ser_rsvd", {ILLEGAL_O, ID_HOLD_O}, 2'b10);
		end_sim();
	end
endmodule // fciu_tb_top
